// file: design/ilas_config_capture.sv
// Read-only bank of link configuration captured from lanes 0 and 1.
// Assumes a simple read/write strobe port and in-order octet streams.
`timescale 1ns/1ps
`include "ilas_capture_cfg.svh"
module ilas_config_capture #(
   parameter int LANES = 2
) (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Configuration port
   input wire logic regRdEn,
   input wire logic regWrEn,
   input wire logic [11:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // Checksum method select from the link control register
   input wire logic checksumMode,
   // Per-lane configuration octet streams
   input wire logic [LANES-1:0] laneValid,
   input wire logic [LANES-1:0][3:0] laneIndex,
   input wire logic [LANES-1:0][7:0] laneOctet,
   // Per-lane status
   output logic [LANES-1:0] laneSumReady,
   output logic [LANES-1:0] laneMismatch
);
   ilas_capture_pkg::cfg_octets_t laneOct [LANES];
   logic [7:0] laneCalc [LANES];
   logic [LANES-1:0] laneBusy;
   logic [7:0] regRdData_r;
   logic regRdValid_r;
   logic [7:0] rdMux;

   // One capture engine per lane
   for (genvar g = 0; g < LANES; g++) begin : gLane
      ilas_lane_capture uLane (
         .clock(clock),
         .nrst(nrst),
         .octValid(laneValid[g]),
         .octIndex(laneIndex[g]),
         .octData(laneOctet[g]),
         .checksumMode(checksumMode),
         .octets(laneOct[g]),
         .calcSum(laneCalc[g]),
         .sumReady(laneSumReady[g]),
         .mismatch(laneMismatch[g]),
         .busy(laneBusy[g])
      );
   end

   // Read decode; reserved bits and unknown offsets read zero
   always_comb begin
      rdMux = `CAP_RESET;
      case (regAddr)
         `OFS_CONV_COUNT: rdMux = laneOct[0][`OCT_M];
         `OFS_CTRL_RES: begin
            rdMux[`FLD_CS_HI:`FLD_CS_LO] =
               laneOct[0][`OCT_CS_N][`FLD_CS_HI:`FLD_CS_LO];
            rdMux[`FLD_LOW5_HI:0] =
               laneOct[0][`OCT_CS_N][`FLD_LOW5_HI:0];
         end
         `OFS_SUBCLASS_NP: begin
            rdMux[7:`FLD_TOP3_LO] =
               laneOct[0][`OCT_SUB_NP][7:`FLD_TOP3_LO];
            rdMux[`FLD_LOW5_HI:0] =
               laneOct[0][`OCT_SUB_NP][`FLD_LOW5_HI:0];
         end
         `OFS_VERSION_S: begin
            rdMux[7:`FLD_TOP3_LO] =
               laneOct[0][`OCT_VER_S][7:`FLD_TOP3_LO];
            rdMux[`FLD_LOW5_HI:0] =
               laneOct[0][`OCT_VER_S][`FLD_LOW5_HI:0];
         end
         `OFS_DENSITY_CF: begin
            rdMux[`FLD_HD_BIT] =
               laneOct[0][`OCT_HD_CF][`FLD_HD_BIT];
            rdMux[`FLD_LOW5_HI:0] =
               laneOct[0][`OCT_HD_CF][`FLD_LOW5_HI:0];
         end
         `OFS_RES_ONE: rdMux = laneOct[0][`OCT_RES1];
         `OFS_RES_TWO: rdMux = laneOct[0][`OCT_RES2];
         `OFS_L0_RX_SUM: rdMux = laneOct[0][`OCT_SUM];
         `OFS_L0_CALC_SUM: rdMux = laneCalc[0];
         `OFS_L1_ID: begin
            rdMux[`FLD_LOW5_HI:0] =
               laneOct[1][`OCT_LID][`FLD_LOW5_HI:0];
         end
         `OFS_L1_RX_SUM: rdMux = laneOct[1][`OCT_SUM];
         `OFS_L1_CALC_SUM: rdMux = laneCalc[1];
         default: rdMux = `CAP_RESET;
      endcase
   end

   // Registered read answer; writes have no effect on any capture
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         regRdData_r <= `CAP_RESET;
         regRdValid_r <= 1'b0;
      end else begin
         regRdValid_r <= regRdEn;
         if (regRdEn) begin
            regRdData_r <= rdMux;
         end
      end
   end

   assign regRdData = regRdData_r;
   assign regRdValid = regRdValid_r;

   // Checks on the capture bank
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   a_read_latency: assert property (
      regRdEn |=> regRdValid && regRdData == $past(rdMux))
      else $error("read answer not one cycle after request");

   a_valid_pulse: assert property (
      regRdValid |-> $past(regRdEn))
      else $error("read valid without a request");

   a_ctrl_res_reserved: assert property (
      regRdValid && $past(regAddr) == `OFS_CTRL_RES |-> !regRdData[5])
      else $error("reserved bit 5 of control/resolution not zero");

   a_density_reserved: assert property (
      regRdValid && $past(regAddr) == `OFS_DENSITY_CF
      |-> regRdData[6:5] == 2'b00)
      else $error("reserved bits of density register not zero");

   a_lane1_id_top: assert property (
      regRdValid && $past(regAddr) == `OFS_L1_ID
      |-> regRdData[7:5] == 3'b000
          && regRdData[4:0] == $past(laneOct[1][`OCT_LID][4:0]))
      else $error("lane 1 identifier read wrong");

   a_count_read: assert property (
      regRdEn && regAddr == `OFS_CONV_COUNT
      |=> regRdData == $past(laneOct[0][`OCT_M]))
      else $error("converter count read does not match capture");

   a_sum_timing: assert property (
      laneValid[0] && laneIndex[0] == `OCT_SUM && laneBusy[0]
      |=> !laneSumReady[0] ##1 laneSumReady[0])
      else $error("lane 0 checksum not ready two cycles after end");

   a_mismatch_cause: assert property (
      laneSumReady[0] |-> laneMismatch[0]
         == (laneCalc[0] != laneOct[0][`OCT_SUM]))
      else $error("lane 0 mismatch disagrees with sums");

   a_mismatch_lane1: assert property (
      laneSumReady[1] |-> laneMismatch[1]
         == (laneCalc[1] != laneOct[1][`OCT_SUM]))
      else $error("lane 1 mismatch disagrees with sums");

   a_write_ignored: assert property (
      regWrEn && !(|laneValid) && !$past(laneValid[0])
      |=> $stable(laneOct[0]) && $stable(laneCalc[0]))
      else $error("software write changed a capture register");

   a_unmapped_zero: assert property (
      regRdEn && regAddr == `OFS_L2_ID |=> regRdData == 8'h00)
      else $error("lane 2 identifier not reading zero");

   // Scenarios worth seeing
   c_seq_done: cover property (laneSumReady[0] && !laneMismatch[0]);
   c_seq_bad: cover property (laneSumReady[0] && laneMismatch[0]);
   c_lane1_done: cover property (laneSumReady[1]);
   c_mode_octet: cover property (checksumMode && laneSumReady[0]);
   c_read_calc: cover property (regRdEn && regAddr == `OFS_L0_CALC_SUM);
endmodule

// file: design/ilas_capture_cfg.svh
// Offsets, field positions, reset values and octet indices for the
// capture bank. Assumes the link layer delivers in-order config octets.
// Functional notes
// - Converter count kept as count minus one
// - Control bits field 7:6, sender sends zero
// - Resolution minus one in five-bit field
// - Subclass code in three bits, 000/001
// - Bits per sample minus one, five bits
// - Samples per frame minus one, low bits
// - Density flag in bit 7
// - Control words field low five, sender zero
// - Two reserved octets captured whole, read-only
// - Received checksum stored per lane
// - Local checksum, method from mode bit
// - Lane 1 identifier in low five bits
// - Lane 1 computed checksum, same method
`ifndef ILAS_CAPTURE_CFG_SVH
`define ILAS_CAPTURE_CFG_SVH

// Register offsets on the configuration port
`define OFS_CONV_COUNT 12'h406
`define OFS_CTRL_RES 12'h407
`define OFS_SUBCLASS_NP 12'h408
`define OFS_VERSION_S 12'h409
`define OFS_DENSITY_CF 12'h40a
`define OFS_RES_ONE 12'h40b
`define OFS_RES_TWO 12'h40c
`define OFS_L0_RX_SUM 12'h40d
`define OFS_L0_CALC_SUM 12'h40e
`define OFS_L1_ID 12'h412
`define OFS_L1_RX_SUM 12'h415
`define OFS_L1_CALC_SUM 12'h416
`define OFS_L2_ID 12'h41a

// Reset value of every capture register
`define CAP_RESET 8'h00

// Octet positions within the link configuration sequence
`define OCT_FIRST 4'h0
`define OCT_BID 4'h1
`define OCT_LID 4'h2
`define OCT_SCR_L 4'h3
`define OCT_F 4'h4
`define OCT_K 4'h5
`define OCT_M 4'h6
`define OCT_CS_N 4'h7
`define OCT_SUB_NP 4'h8
`define OCT_VER_S 4'h9
`define OCT_HD_CF 4'ha
`define OCT_RES1 4'hb
`define OCT_RES2 4'hc
`define OCT_SUM 4'hd

// Field positions
`define FLD_CS_HI 7
`define FLD_CS_LO 6
`define FLD_LOW5_HI 4
`define FLD_TOP3_LO 5
`define FLD_HD_BIT 7
`define FLD_PHADJ_BIT 5
`define FLD_ADJDIR_BIT 6
`define FLD_SCR_BIT 7

`endif

// file: design/ilas_capture_pkg.sv
// Types shared by the capture bank and its lane engine.
// Assumes the cfg header carries all numeric constants.
package ilas_capture_pkg;
   typedef enum logic {CAP_IDLE, CAP_BUSY} capture_state_t;
   typedef logic [13:0][7:0] cfg_octets_t;
endpackage

// file: design/ilas_lane_capture.sv
// One lane's configuration capture and checksum engine.
// Assumes octets arrive in order, index 0 first, one per valid cycle.
`timescale 1ns/1ps
`include "ilas_capture_cfg.svh"
module ilas_lane_capture (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Octet stream from the lane
   input wire logic octValid,
   input wire logic [3:0] octIndex,
   input wire logic [7:0] octData,
   // Checksum method select
   input wire logic checksumMode,
   // Captured results
   output ilas_capture_pkg::cfg_octets_t octets,
   output logic [7:0] calcSum,
   output logic sumReady,
   output logic mismatch,
   output logic busy
);
   ilas_capture_pkg::capture_state_t state_r;
   ilas_capture_pkg::cfg_octets_t oct_r;
   logic [7:0] calcSum_r;
   logic sumReady_r;
   logic mismatch_r;
   logic last_r;
   logic [7:0] sumNow;
   logic startOct;
   logic endOct;

   // Mode 0 adds the fields, mode 1 adds the whole octets
   function automatic logic [7:0] lane_sum(
         input ilas_capture_pkg::cfg_octets_t o, input logic mode);
      logic [7:0] s;
      s = 8'h00;
      if (mode) begin
         for (int i = 0; i < 13; i++) begin
            s = s + o[i];
         end
      end else begin
         s = o[0] + 8'(o[1][3:0]) + 8'(o[1][7:4]) + 8'(o[2][4:0]);
         s = s + 8'(o[2][`FLD_PHADJ_BIT]) + 8'(o[2][`FLD_ADJDIR_BIT]);
         s = s + 8'(o[3][`FLD_SCR_BIT]) + 8'(o[3][4:0]) + o[4];
         s = s + 8'(o[5][4:0]) + o[6] + 8'(o[7][4:0]) + 8'(o[7][7:6]);
         s = s + 8'(o[8][4:0]) + 8'(o[8][7:5]) + 8'(o[9][4:0]);
         s = s + 8'(o[9][7:5]) + 8'(o[10][4:0]) + 8'(o[10][7]);
      end
      return s;
   endfunction

   assign startOct = octValid && (octIndex == `OCT_FIRST);
   assign endOct = octValid && (octIndex == `OCT_SUM)
                   && (state_r == ilas_capture_pkg::CAP_BUSY);
   assign sumNow = lane_sum(oct_r, checksumMode);

   // Sequence tracking
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_r <= ilas_capture_pkg::CAP_IDLE;
      end else begin
         case (state_r)
            ilas_capture_pkg::CAP_IDLE: begin
               if (startOct) begin
                  state_r <= ilas_capture_pkg::CAP_BUSY;
               end
            end
            ilas_capture_pkg::CAP_BUSY: begin
               if (endOct) begin
                  state_r <= ilas_capture_pkg::CAP_IDLE;
               end
            end
            default: state_r <= ilas_capture_pkg::CAP_IDLE;
         endcase
      end
   end

   // Octet store, held until the next sequence writes over it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         oct_r <= '0;
      end else if (octValid && octIndex <= `OCT_SUM
                   && (startOct || state_r == ilas_capture_pkg::CAP_BUSY)) begin
         oct_r[octIndex] <= octData;
      end
   end

   // Checksum and compare one cycle after the last octet lands
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         last_r <= 1'b0;
         calcSum_r <= `CAP_RESET;
         sumReady_r <= 1'b0;
         mismatch_r <= 1'b0;
      end else begin
         last_r <= endOct;
         sumReady_r <= last_r;
         if (last_r) begin
            calcSum_r <= sumNow;
            mismatch_r <= (sumNow != oct_r[`OCT_SUM]);
         end else if (startOct) begin
            mismatch_r <= 1'b0;
         end
      end
   end

   assign octets = oct_r;
   assign calcSum = calcSum_r;
   assign sumReady = sumReady_r;
   assign mismatch = mismatch_r;
   assign busy = (state_r == ilas_capture_pkg::CAP_BUSY);
endmodule

// file: tb/ilas_tx_model.sv
// Lane transmitter model sending one link configuration sequence.
// Assumes the bench calls send from its main process.
`timescale 1ns/1ps
module ilas_tx_model (
   // Clock
   input wire logic clock,
   // Octet stream towards the receiver
   output logic valid,
   output logic [3:0] index,
   output logic [7:0] octet
);
   initial begin
      valid = 1'b0;
      index = 4'hf;
      octet = 8'h00;
   end

   // Octets 0..13 in order; released lines show inverted data
   task automatic send(input ilas_capture_pkg::cfg_octets_t o,
                       input int gap);
      @(posedge clock);
      for (int i = 0; i < 14; i++) begin
         valid <= 1'b1;
         index <= i[3:0];
         octet <= o[i];
         @(posedge clock);
         // Idle cycles between octets, none after the last one
         for (int g = 0; g < gap && i < 13; g++) begin
            valid <= 1'b0;
            octet <= ~o[i];
            @(posedge clock);
         end
      end
      // Returns at the edge that takes the last octet
      valid <= 1'b0;
      index <= 4'hf;
      octet <= ~o[13];
   endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the configuration capture bank.
// Assumes two transmitter models feeding lanes 0 and 1.
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic regRdEn = 1'b0;
   logic regWrEn = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [7:0] regWrData = 8'h00;
   logic checksumMode = 1'b0;
   logic [7:0] regRdData;
   logic regRdValid;
   wire [1:0] laneValid;
   wire [1:0][3:0] laneIndex;
   wire [1:0][7:0] laneOctet;
   logic [1:0] laneSumReady;
   logic [1:0] laneMismatch;
   int err_count = 0;
   int n_checks = 0;
   ilas_capture_pkg::cfg_octets_t o0;
   ilas_capture_pkg::cfg_octets_t o1;

   always #4 clock = ~clock;

   ilas_config_capture #(.LANES(2)) uut (.clock(clock), .nrst(nrst),
      .regRdEn(regRdEn), .regWrEn(regWrEn), .regAddr(regAddr),
      .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .checksumMode(checksumMode),
      .laneValid(laneValid), .laneIndex(laneIndex),
      .laneOctet(laneOctet), .laneSumReady(laneSumReady),
      .laneMismatch(laneMismatch));
   ilas_tx_model tx0 (.clock(clock), .valid(laneValid[0]),
      .index(laneIndex[0]), .octet(laneOctet[0]));
   ilas_tx_model tx1 (.clock(clock), .valid(laneValid[1]),
      .index(laneIndex[1]), .octet(laneOctet[1]));

   // Reference checksum for both methods
   function automatic logic [7:0] fsum(
      input ilas_capture_pkg::cfg_octets_t o, input logic m);
      logic [7:0] s;
      s = 8'h00;
      if (m) begin
         for (int i = 0; i < 13; i++) s += o[i];
      end else begin
         s = o[0] + o[1][3:0] + o[1][7:4] + o[2][4:0] + o[2][5] + o[2][6]
            + o[3][4:0] + o[3][7] + o[4] + o[5][4:0] + o[6] + o[7][4:0]
            + o[7][7:6] + o[8][4:0] + o[8][7:5] + o[9][4:0] + o[9][7:5]
            + o[10][4:0] + o[10][7];
      end
      return s;
   endfunction

   task automatic chk8(input string n, input logic [7:0] e,
                       input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk1(input string n, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask

   // One read cycle, answer one cycle after the request edge
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clock);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRdEn <= 1'b0;
      #1;
      chk1("read valid", 1'b1, regRdValid);
      chk8($sformatf("reg %h", a), e, regRdData);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrEn <= 1'b0;
   endtask

   // Called at the edge taking the last octet; pulse shows after the next
   task automatic wait_sum(input int l, input logic m);
      int k;
      k = 0;
      while (laneSumReady[l] !== 1'b1 && k < 8) begin
         @(posedge clock);
         #1;
         k++;
      end
      chk8("sum delay", 8'h01, k[7:0]);
      chk1("mismatch", m, laneMismatch[l]);
      @(posedge clock);
      #1;
      chk1("sum pulse end", 1'b0, laneSumReady[l]);
   endtask

   task automatic check_lane0(input logic m);
      rd(12'h406, o0[6]);
      rd(12'h407, o0[7] & 8'hdf);
      rd(12'h408, o0[8]);
      rd(12'h409, o0[9]);
      rd(12'h40a, o0[10] & 8'h9f);
      rd(12'h40b, o0[11]);
      rd(12'h40c, o0[12]);
      rd(12'h40d, o0[13]);
      rd(12'h40e, fsum(o0, m));
   endtask

   task automatic test_reset();
      logic [11:0] offs [14] = '{12'h406, 12'h407, 12'h408, 12'h409,
         12'h40a, 12'h40b, 12'h40c, 12'h40d, 12'h40e, 12'h412, 12'h415,
         12'h416, 12'h41a, 12'h3ff};
      foreach (offs[i]) rd(offs[i], 8'h00);
      $display("test reset done");
   endtask

   task automatic test_lane0_good();
      checksumMode <= 1'b1;
      o0 = {8'h00, 8'h3c, 8'ha5, 8'he0, 8'h20, 8'h2f, 8'h2f, 8'h01,
            8'h1f, 8'h01, 8'h81, 8'h00, 8'h31, 8'h5a};
      o0[13] = fsum(o0, 1'b1);
      tx0.send(o0, 0);
      wait_sum(0, 1'b0);
      check_lane0(1'b1);
      $display("test lane0 good done");
   endtask

   task automatic test_lane0_bad();
      checksumMode <= 1'b0;
      o0 = {8'h00, 8'h11, 8'h22, 8'h00, 8'h03, 8'h0f, 8'h0b, 8'h00,
            8'h1f, 8'h03, 8'h83, 8'h00, 8'hf2, 8'h01};
      o0[13] = fsum(o0, 1'b0) + 8'h01;
      tx0.send(o0, 1);
      wait_sum(0, 1'b1);
      check_lane0(1'b0);
      $display("test lane0 bad done");
   endtask

   task automatic test_lane1();
      checksumMode <= 1'b1;
      o1 = {8'h00, 8'h07, 8'h09, 8'h80, 8'h20, 8'h2f, 8'h0f, 8'h00,
            8'h1f, 8'h00, 8'h80, 8'h61, 8'h00, 8'h44};
      o1[13] = fsum(o1, 1'b1);
      tx1.send(o1, 0);
      wait_sum(1, 1'b0);
      rd(12'h412, o1[2] & 8'h1f);
      rd(12'h415, o1[13]);
      rd(12'h416, fsum(o1, 1'b1));
      chk1("lane0 mismatch held", 1'b1, laneMismatch[0]);
      $display("test lane1 done");
   endtask

   task automatic test_readonly();
      wr(12'h406, 8'hff);
      wr(12'h416, 8'h5a);
      rd(12'h406, o0[6]);
      rd(12'h416, fsum(o1, 1'b1));
      $display("test readonly done");
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      test_reset();
      test_lane0_good();
      test_lane0_bad();
      test_lane1();
      test_readonly();
      summarize();
   end

   // Watchdog, far beyond the expected run of about 150 cycles
   initial begin
      repeat (5000) @(posedge clock);
      err_count++;
      $display("watchdog expired");
      summarize();
   end
endmodule
